// File: bench/chip_select_match_logic_test.sv
`timescale 1ns/1ps
module chip_select_match_logic_test;
  import csel_pkg::*;
  // design inputs and outputs
  logic        mclk, rst, ce, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic        pready, pslverr, er_v;
  logic [23:0] addr;
  logic [2:0]  function_code_lines;
  logic        read_write, address_strobe_n, data_strobe_n;
  logic [1:0]  transfer_size_lines;
  logic        slow_peripheral_clock, iack_from_pin;
  logic        ext_data_size_acknowledge_n, ext_autovector_n;
  logic [11:0] select_n;
  logic        int_data_size_acknowledge_n, int_autovector_n, wait_insert, cycle_terminate;
  logic [3:0]  plat; // partner acknowledge delay
  logic        pav;  // partner answers with its autovector line
  int          n_errors, checks;

  csel_match uut (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .addr(addr), .function_code_lines(function_code_lines),
    .read_write(read_write), .transfer_size_lines(transfer_size_lines),
    .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
    .slow_peripheral_clock(slow_peripheral_clock), .iack_from_pin(iack_from_pin),
    .ext_data_size_acknowledge_n(ext_data_size_acknowledge_n), .ext_autovector_n(ext_autovector_n),
    .select_n(select_n), .int_data_size_acknowledge_n(int_data_size_acknowledge_n), .int_autovector_n(int_autovector_n),
    .wait_insert(wait_insert), .cycle_terminate(cycle_terminate));
  periph_model far (.mclk(mclk), .address_strobe_n(address_strobe_n), .sel_n(select_n[1]),
    .lat(plat), .use_autovector_request(pav), .ext_data_size_acknowledge_n(ext_data_size_acknowledge_n),
    .ext_autovector_n(ext_autovector_n));

  // 20 MHz clock
  always #25 mclk = ~mclk;

  task automatic print_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      n_errors++;
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({31'h0, er_v}, 32'h0);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_v, e);
  endtask

  // option word from its fields
  function automatic logic [15:0] opt(input logic m, input logic [1:0] b, input logic [1:0] r,
      input logic s, input logic [3:0] k, input logic [1:0] sp, input logic [2:0] p,
      input logic v);
    return {m, b, r, s, k, sp, p, v};
  endfunction

  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  // start a bus cycle; data strobe falls on the same edge as address strobe, only when ds is set
  task automatic bon(input logic [23:0] a, input logic [2:0] fc, input logic rw,
      input logic [1:0] sz, input logic ds);
    @(posedge mclk);
    addr <= a;
    function_code_lines <= fc;
    read_write <= rw;
    transfer_size_lines <= sz;
    address_strobe_n <= 1'b0;
    data_strobe_n <= ~ds;
  endtask

  // end the cycle; every select and acknowledge must let go
  task automatic boff();
    @(posedge mclk);
    address_strobe_n <= 1'b1;
    data_strobe_n <= 1'b1;
    step(2);
    chk({select_n, int_data_size_acknowledge_n, int_autovector_n, cycle_terminate}, {12'hfff, 3'b110});
  endtask

  // watchdog, far beyond the thousand or so edges the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end

  initial begin
    int i, n;
    logic e;
    logic [1:0] pc, b;
    logic [2:0] pf, pr;
    mclk = 1'b0; rst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; addr = 24'h0; function_code_lines = FC_SDATA;
    read_write = 1'b1; transfer_size_lines = 2'h2; address_strobe_n = 1'b1;
    data_strobe_n = 1'b1; slow_peripheral_clock = 1'b0; iack_from_pin = 1'b1; plat = 4'h1;
    n_errors = 0; checks = 0;
    pav = 1'b0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    // reset values and an unmapped place
    rdchk(OFS_OPTION, 32'h7b70);
    rdchk(OFS_OPTION + 8'h04, 32'h0);
    rdchk(OFS_BASE, 32'h0007);
    rdchk(OFS_PINASSIGN, 32'h3);
    apb(1'b0, 8'h30, 32'h0);
    chk({er_v, rd_v[30:0]}, 32'h80000000);
    // discrete output port, top bit dead
    wr(OFS_PORT, 32'hff);
    rdchk(OFS_PORT, 32'h7f);
    wr(OFS_PINASSIGN + 8'h10, 32'h0);
    wr(OFS_PORT, 32'h7e);
    rdchk(OFS_PORT, 32'h7e);
    chk(select_n[4], 32'h0);
    wr(OFS_PINASSIGN + 8'h10, 32'h1);
    // boot select out of reset, 13 wait states
    bon(24'h000400, FC_SPROG, 1'b1, 2'h2, 1'b0);
    step(2);
    chk({select_n[0], wait_insert}, 32'h1);
    n = 2;
    do begin
      step(1);
      n++;
    end while (int_data_size_acknowledge_n !== 1'b0 && n < 40);
    chk(n, 14);
    chk({select_n[0], cycle_terminate}, 32'h1);
    boff();
    // byte lanes against port width, 16 combinations
    wr(OFS_BASE + 8'h04, 32'h2000);
    for (i = 0; i < 16; i++) begin
      pc = i[3] ? PA_CS8 : PA_CS16;
      b = i[2:1];
      wr(OFS_PINASSIGN + 8'h04, {30'h0, pc});
      wr(OFS_OPTION + 8'h04, {16'h0, opt(1'b0, b, 2'h3, 1'b0, 4'h0, SPC_SU, 3'h0, 1'b0)});
      e = (b != BYTE_OFF) && (pc == PA_CS8 || b == BYTE_BOTH || ((b == BYTE_LOWER) == i[0]));
      bon({23'h100000, i[0]}, FC_SDATA, 1'b1, SIZ_BYTE, 1'b0);
      step(2);
      chk(select_n[1], {31'h0, ~e});
      boff();
    end
    // direction and space codes against read/write and function code
    for (i = 0; i < 64; i++) begin
      wr(OFS_OPTION + 8'h04,
         {16'h0, opt(1'b0, BYTE_BOTH, i[1:0], 1'b0, 4'h0, i[3:2], 3'h0, 1'b0)});
      e = (i[0] & i[4] | i[1] & ~i[4]) & (i[2] & i[5] | i[3] & ~i[5]);
      bon(24'h200002, i[5] ? FC_UDATA : FC_SDATA, i[4], 2'h2, 1'b0);
      step(2);
      chk(select_n[1], {31'h0, ~e});
      boff();
    end
    // data strobe timing, then e-clock timing with the strobe bit ignored
    for (i = 0; i < 2; i++) begin
      wr(OFS_OPTION + 8'h04,
         {16'h0, opt(i[0], BYTE_BOTH, 2'h3, 1'b1, 4'h0, SPC_SU, 3'h0, 1'b0)});
      bon(24'h200002, FC_SDATA, 1'b1, 2'h2, 1'b0);
      step(3);
      chk(select_n[1], 32'h1);
      @(posedge mclk);
      if (i == 0)
        data_strobe_n <= 1'b0;
      else
        slow_peripheral_clock <= 1'b1;
      step(2);
      chk(select_n[1], 32'h0);
      boff();
      slow_peripheral_clock <= 1'b0;
    end
    // external acknowledge from a prompt, a middling and a slow device, last one by autovector
    wr(OFS_OPTION + 8'h04, {16'h0, opt(1'b0, BYTE_BOTH, 2'h3, 1'b0, ACK_EXT, SPC_SU, 3'h0, 1'b0)});
    for (i = 1; i < 16; i += 7) begin
      plat <= i[3:0];
      pav <= (i == 15);
      bon(24'h200002, FC_SDATA, 1'b1, 2'h2, 1'b0);
      n = 0;
      do begin
        step(1);
        n++;
      end while (cycle_terminate !== 1'b1 && n < 30);
      chk(n, i + 3);
      boff();
    end
    // interrupt acknowledge: priority, any-level code, on-chip source
    wr(OFS_BASE + 8'h08, 32'hfffb);
    wr(OFS_PINASSIGN + 8'h08, 32'h3);
    for (i = 0; i < 4; i++) begin
      pf = (i == 2) ? PRI_ANY : 3'h3;
      pr = (i == 0 || i == 3) ? 3'h3 : 3'h5;
      e = (i != 1) && (i != 3);
      wr(OFS_OPTION + 8'h08, {16'h0, opt(1'b0, BYTE_LOWER, 2'h1, 1'b0, 4'h0, SPC_CPU, pf, 1'b1)});
      @(posedge mclk);
      iack_from_pin <= (i != 3);
      bon({20'hfffff, pr, 1'b1}, FC_CPU, 1'b1, SIZ_BYTE, 1'b0);
      step(3);
      chk({select_n[2], int_autovector_n, cycle_terminate}, {29'h0, ~e, ~e, e});
      boff();
    end
    print_verdict();
  end
endmodule

// File: bench/periph_model.sv
`timescale 1ns/1ps
// external peripheral that answers its select with a late data acknowledge or autovector
module periph_model (
  // bus side
  input  wire logic       mclk,
  input  wire logic       address_strobe_n,
  input  wire logic       sel_n,
  input  wire logic [3:0] lat,
  input  wire logic       use_autovector_request,
  // acknowledge lines, pulled up when released
  output logic            ext_data_size_acknowledge_n,
  output logic            ext_autovector_n
);
  logic [3:0] cnt; // edges since select seen
  initial begin
    cnt = 4'h0;
    ext_data_size_acknowledge_n = 1'b1;
    ext_autovector_n = 1'b1; // released until asked for a vector
  end
  // slow device: holds off acknowledge for lat edges, drops it with strobe
  always @(posedge mclk) begin
    if (address_strobe_n || sel_n) begin
      cnt <= 4'h0;
      ext_data_size_acknowledge_n <= 1'b1;
      ext_autovector_n <= 1'b1;
    end else if (cnt == lat) begin
      if (use_autovector_request)
        ext_autovector_n <= 1'b0;
      else
        ext_data_size_acknowledge_n <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// File: hw/csel_match.sv
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module csel_match #(
  parameter int CHANNELS = csel_pkg::NCH_DEFAULT
) (
  // clock, reset, enable
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                ce,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // processor bus cycle
  input  wire logic [23:0]         addr,
  input  wire logic [2:0]          function_code_lines,
  input  wire logic                read_write,
  input  wire logic [1:0]          transfer_size_lines,
  input  wire logic                address_strobe_n,
  input  wire logic                data_strobe_n,
  input  wire logic                slow_peripheral_clock,
  input  wire logic                iack_from_pin,
  input  wire logic                ext_data_size_acknowledge_n,
  input  wire logic                ext_autovector_n,
  // outputs to pins and bus controller
  output logic [CHANNELS-1:0]      select_n,
  output logic                     int_data_size_acknowledge_n,
  output logic                     int_autovector_n,
  output logic                     wait_insert,
  output logic                     cycle_terminate
);
  import csel_pkg::*;

  // programmable state
  logic [15:0] opt  [CHANNELS];        // option words
  logic [15:0] base [CHANNELS];        // base address and block size
  logic [1:0]  pa   [CHANNELS];        // pin assignment codes
  logic [6:0]  port_data;              // discrete output bits, bit 7 absent
  logic [15:0] next_opt  [CHANNELS];
  logic [15:0] next_base [CHANNELS];
  logic [1:0]  next_pa   [CHANNELS];
  logic [6:0]  next_port;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  // bus cycle state
  logic                slow_peripheral_clock_q;         // E-clock level last cycle
  logic [3:0]          wait_cnt;       // wait states since strobe
  logic [CHANNELS-1:0] sel;            // internal select state
  logic                next_slow_peripheral_clock_q;
  logic [3:0]          next_wait_cnt;
  logic [CHANNELS-1:0] next_sel;
  logic [CHANNELS-1:0] next_select_n;
  logic                next_int_data_size_acknowledge_n;
  logic                next_int_autovector_n;
  logic                next_wait_insert;
  logic                next_cycle_terminate;

  // match decode
  logic [CHANNELS-1:0] hit;            // channel matches current access
  logic                iack;           // interrupt acknowledge cycle
  logic                as_now;
  logic                ds_now;
  logic                slow_peripheral_clock_rise;
  logic                ack_any;        // an async hit owns the acknowledge
  logic [3:0]          ack_need;       // wait states that hit asks for
  logic                autovector_request_any;       // a hit asks for autovector
  logic                mapped;
  logic [31:0]         rd_val;
  logic [3:0]          idx;

  assign as_now    = ~address_strobe_n;
  assign ds_now    = ~data_strobe_n;
  assign slow_peripheral_clock_rise = slow_peripheral_clock & ~slow_peripheral_clock_q;
  assign idx       = paddr[5:2];

  // per-channel compare of the current access
  always_comb begin
    logic [1:0] bytef;
    logic [1:0] rwf;
    logic [2:0] pri;
    logic       addr_ok;
    logic       rw_ok;
    logic       spc_ok;
    logic       byte_ok;
    bytef   = BYTE_OFF;
    rwf     = 2'h0;
    pri     = PRI_ANY;
    addr_ok = 1'b0;
    rw_ok   = 1'b0;
    spc_ok  = 1'b0;
    byte_ok = 1'b0;
    iack = (function_code_lines == FC_CPU) && (addr[19:16] == IACK_TYPE);
    ack_any  = 1'b0;
    ack_need = 4'h0;
    autovector_request_any = 1'b0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      bytef = opt[i][OPT_BYTE_HI:OPT_BYTE_LO];
      rwf   = opt[i][OPT_RW_HI:OPT_RW_LO];
      pri   = opt[i][OPT_PRI_HI:OPT_PRI_LO];
      // only the upper lines chosen by block size take part
      addr_ok = ((addr[23:11] ^ base[i][BASE_HI:BASE_LO])
                 & blk_mask(base[i][BLK_HI:0])) == 13'h0000;
      // direction: reserved code zero never matches
      rw_ok = read_write ? rwf[0] : rwf[1];
      unique case (opt[i][OPT_SPC_HI:OPT_SPC_LO])
        SPC_CPU: begin
          // priority only shapes this response, never interrupt recognition
          spc_ok = (function_code_lines == FC_CPU)
                   && (pri == PRI_ANY || pri == addr[3:1]);
        end
        SPC_USER: spc_ok = (function_code_lines == FC_UDATA)
                           || (function_code_lines == FC_UPROG);
        SPC_SUPV: spc_ok = (function_code_lines == FC_SDATA)
                           || (function_code_lines == FC_SPROG);
        SPC_SU: spc_ok = (function_code_lines == FC_UDATA)
                         || (function_code_lines == FC_UPROG)
                         || (function_code_lines == FC_SDATA)
                         || (function_code_lines == FC_SPROG);
      endcase
      if (pa[i] == PA_CS16) begin
        // lower lane is the odd byte; wider transfers at even use both
        unique case (bytef)
          BYTE_OFF:   byte_ok = 1'b0;
          BYTE_LOWER: byte_ok = addr[0] | (transfer_size_lines != SIZ_BYTE);
          BYTE_UPPER: byte_ok = ~addr[0];
          BYTE_BOTH:  byte_ok = 1'b1;
        endcase
      end else begin
        byte_ok = (bytef != BYTE_OFF);
      end
      // on-chip interrupt sources answer their own acknowledge
      hit[i] = addr_ok & rw_ok & spc_ok & byte_ok
               & ~(iack & ~iack_from_pin);
      // descending loop: lowest numbered hit ends up owning ack
      if (hit[i] && !opt[i][OPT_MODE]
          && opt[i][OPT_ACK_HI:OPT_ACK_LO] != ACK_EXT) begin
        ack_any  = 1'b1;
        ack_need = (opt[i][OPT_ACK_HI:OPT_ACK_LO] == ACK_FAST)
                   ? 4'h0 : opt[i][OPT_ACK_HI:OPT_ACK_LO];
      end
      if (hit[i] && iack && opt[i][OPT_AUTOVECTOR_REQUEST]) begin
        autovector_request_any = 1'b1;
      end
    end
  end

  // register read mux and address decode
  always_comb begin
    mapped = 1'b0;
    rd_val = 32'h0000_0000;
    if (paddr[1:0] == 2'h0 && 32'(idx) < CHANNELS) begin
      unique case (paddr & REGION_MASK)
        OFS_OPTION: begin
          mapped = 1'b1;
          rd_val = {16'h0000, opt[idx]};
        end
        OFS_BASE: begin
          mapped = 1'b1;
          rd_val = {16'h0000, base[idx]};
        end
        OFS_PINASSIGN: begin
          mapped = 1'b1;
          rd_val = {30'h0, pa[idx]};
        end
        default: ;
      endcase
    end
    if (paddr == OFS_PORT) begin
      mapped = 1'b1;
      rd_val = {25'h0, port_data};
    end
    if (paddr == OFS_STATUS) begin
      mapped = 1'b1;
      rd_val = 32'(sel);
    end
  end

  // apb next values; one wait state so read data leaves a flop
  always_comb begin
    next_opt     = opt;
    next_base    = base;
    next_pa      = pa;
    next_port    = port_data;
    next_pready  = psel & penable & ~pready;
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_pslverr = ~mapped;
      if (!pwrite) begin
        next_prdata = rd_val;
      end
    end
    // writes land on the edge that completes the access
    if (psel && penable && pready && pwrite && mapped) begin
      if (paddr == OFS_PORT) begin
        next_port = pwdata[6:0];
      end else if (paddr != OFS_STATUS) begin
        unique case (paddr & REGION_MASK)
          OFS_OPTION:    next_opt[idx]  = pwdata[15:0];
          OFS_BASE:      next_base[idx] = pwdata[15:0];
          OFS_PINASSIGN: next_pa[idx]   = pwdata[1:0];
          default: ;
        endcase
      end
    end
  end

  // register file flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        opt[i]  <= (i == 0) ? BOOT_OPTION_RST : OPTION_RST;
        base[i] <= (i == 0) ? BOOT_BASE_RST : BASE_RST;
        pa[i]   <= (i == 0) ? BOOT_PA_RST : PA_RST;
      end
      port_data <= PORT_RST;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else if (ce) begin
      opt       <= next_opt;
      base      <= next_base;
      pa        <= next_pa;
      port_data <= next_port;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
    end
  end

  // bus cycle next values
  always_comb begin
    logic ack_int;
    logic done;
    ack_int       = 1'b0;
    done          = 1'b0;
    next_slow_peripheral_clock_q   = slow_peripheral_clock;
    next_sel      = sel;
    next_wait_cnt = wait_cnt;
    if (!as_now) begin
      next_wait_cnt = 4'h0;
    end else if (wait_cnt != 4'hf) begin
      next_wait_cnt = wait_cnt + 4'h1;
    end
    for (int i = 0; i < CHANNELS; i++) begin
      if (!as_now) begin
        next_sel[i] = 1'b0;
      end else if (hit[i] && !sel[i]) begin
        if (opt[i][OPT_MODE]) begin
          next_sel[i] = slow_peripheral_clock_rise;
        end else begin
          next_sel[i] = opt[i][OPT_STROBE_SELECT] ? ds_now : 1'b1;
        end
      end
    end
    // counter is cleared while strobe is off, so fast term is zero waits
    ack_int = as_now & ack_any & (wait_cnt >= ack_need);
    next_int_data_size_acknowledge_n      = ~ack_int;
    next_int_autovector_n = ~(as_now & autovector_request_any & iack_from_pin);
    // either autovector source or any acknowledge ends the cycle
    done = ack_int | ~ext_data_size_acknowledge_n | (as_now & autovector_request_any & iack_from_pin)
           | ~ext_autovector_n;
    next_cycle_terminate = as_now & done;
    // without an internal source, keep stretching until the device answers
    next_wait_insert = as_now & ~done;
    for (int i = 0; i < CHANNELS; i++) begin
      if (pa[i] == PA_CS8 || pa[i] == PA_CS16) begin
        next_select_n[i] = ~next_sel[i];
      end else if (pa[i] == PA_DISC && i >= DISC_FIRST && i <= DISC_LAST) begin
        next_select_n[i] = port_data[i - DISC_FIRST];
      end else begin
        next_select_n[i] = 1'b1;
      end
    end
  end

  // bus cycle flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      slow_peripheral_clock_q           <= 1'b0;
      wait_cnt         <= 4'h0;
      sel              <= '0;
      select_n         <= '1;
      int_data_size_acknowledge_n      <= 1'b1;
      int_autovector_n <= 1'b1;
      wait_insert      <= 1'b0;
      cycle_terminate  <= 1'b0;
    end else if (ce) begin
      slow_peripheral_clock_q           <= next_slow_peripheral_clock_q;
      wait_cnt         <= next_wait_cnt;
      sel              <= next_sel;
      select_n         <= next_select_n;
      int_data_size_acknowledge_n      <= next_int_data_size_acknowledge_n;
      int_autovector_n <= next_int_autovector_n;
      wait_insert      <= next_wait_insert;
      cycle_terminate  <= next_cycle_terminate;
    end
  end

  // checks sampled only on enabled edges
  default clocking cb @(posedge mclk iff ce); endclocking
  default disable iff (rst);

  property p_negate;
    !as_now |=> sel == '0;
  endproperty
  a_negate: assert property (p_negate) else $error("select held after strobe");

  property p_strobe_pick;
    $rose(sel[0]) && !$past(opt[0][OPT_MODE]) |->
      $past(hit[0]) && (!$past(opt[0][OPT_STROBE_SELECT]) || $past(ds_now));
  endproperty
  a_strobe_pick: assert property (p_strobe_pick) else $error("async select timing");

  property p_sync_align;
    $rose(sel[1]) && $past(opt[1][OPT_MODE]) |-> $past(slow_peripheral_clock_rise);
  endproperty
  a_sync_align: assert property (p_sync_align) else $error("sync select off slow_peripheral_clock");

  property p_wait_count;
    $fell(int_data_size_acknowledge_n) |-> $past(wait_cnt) >= $past(ack_need) && $past(ack_any);
  endproperty
  a_wait_count: assert property (p_wait_count) else $error("data_size_acknowledge too early");

  property p_ext_wait;
    as_now && !ack_any && !autovector_request_any && ext_data_size_acknowledge_n && ext_autovector_n
      |=> wait_insert && !cycle_terminate;
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("no wait inserted");

  property p_autovector_request_term;
    as_now && !ext_autovector_n |=> cycle_terminate;
  endproperty
  a_autovector_request_term: assert property (p_autovector_request_term) else $error("autovector not terminating");

  property p_onchip_ignore;
    iack && !iack_from_pin |-> hit == '0 ##1 int_autovector_n;
  endproperty
  a_onchip_ignore: assert property (p_onchip_ignore) else $error("on-chip iack answered");

  property p_port_bit7;
    $past(psel && penable && !pready && !pwrite && paddr == OFS_PORT)
      |-> prdata[31:7] == 25'h0;
  endproperty
  a_port_bit7: assert property (p_port_bit7) else $error("port bit7 nonzero");

  property p_reset_bytes;
    $fell(rst) |-> opt[0][OPT_BYTE_HI:OPT_BYTE_LO] == BYTE_BOTH
      && opt[1][OPT_BYTE_HI:OPT_BYTE_LO] == BYTE_OFF;
  endproperty
  a_reset_bytes: assert property (disable iff (1'b0) p_reset_bytes)
    else $error("byte field reset wrong");

  property p_cpu_priority;
    hit[2] && opt[2][OPT_SPC_HI:OPT_SPC_LO] == SPC_CPU |-> function_code_lines == FC_CPU
      && (opt[2][OPT_PRI_HI:OPT_PRI_LO] == PRI_ANY || opt[2][OPT_PRI_HI:OPT_PRI_LO] == addr[3:1]);
  endproperty
  a_cpu_priority: assert property (p_cpu_priority) else $error("priority mismatch hit");
  c_boot_select: cover property ($rose(sel[0]));
  c_int_data_size_acknowledge:   cover property ($fell(int_data_size_acknowledge_n));
  c_int_autovector_request:    cover property ($fell(int_autovector_n));
  c_ext_wait:    cover property (wait_insert [*3]);
endmodule

// File: hw/csel_pkg.sv
// Operation
// - mode bit: zero strobe timing, one E-clock
// - byte field: off, lower, upper, both
// - 8-bit port: any nonzero byte code selects
// - 16-bit port: addr0 and size checked
// - reset clears bytes; boot gets both bytes
// - direction field: read, write, both; zero reserved
// - strobe bit picks address or data strobe
// - ack code: waits, fast, or external
// - external ack: wait until peripheral acknowledges
// - space field restricts by function code
// - processor space: priority must equal addr[3:1]
// - priority zero matches any level
// - priority affects select response only
// - autovector bit drives internal autovector
// - port bits drive pins; bit7 reads zero
// - assert with strobe, or aligned to E-clock
// - base bits compared with upper address
// - on-chip interrupt source: ignore acknowledge
// - any autovector terminates acknowledge cycle
// - block size picks compared address lines
// - pin code sets 8 or 16-bit port
package csel_pkg;
  // register byte offsets, one aligned word per register
  localparam logic [7:0] OFS_OPTION    = 8'h00;
  localparam logic [7:0] OFS_BASE      = 8'h40;
  localparam logic [7:0] OFS_PINASSIGN = 8'h80;
  localparam logic [7:0] OFS_PORT      = 8'hc0;
  localparam logic [7:0] OFS_STATUS    = 8'hc4;
  localparam logic [7:0] REGION_MASK   = 8'hc0;
  localparam int         NCH_DEFAULT   = 12;
  // option word field positions
  localparam int OPT_MODE    = 15;
  localparam int OPT_BYTE_HI = 14;
  localparam int OPT_BYTE_LO = 13;
  localparam int OPT_RW_HI   = 12;
  localparam int OPT_RW_LO   = 11;
  localparam int OPT_STROBE_SELECT    = 10;
  localparam int OPT_ACK_HI  = 9;
  localparam int OPT_ACK_LO  = 6;
  localparam int OPT_SPC_HI  = 5;
  localparam int OPT_SPC_LO  = 4;
  localparam int OPT_PRI_HI  = 3;
  localparam int OPT_PRI_LO  = 1;
  localparam int OPT_AUTOVECTOR_REQUEST    = 0;
  // base word field positions
  localparam int BASE_HI     = 15;
  localparam int BASE_LO     = 3;
  localparam int BLK_HI      = 2;
  // field codes
  localparam logic [1:0] BYTE_OFF   = 2'h0;
  localparam logic [1:0] BYTE_LOWER = 2'h1;
  localparam logic [1:0] BYTE_UPPER = 2'h2;
  localparam logic [1:0] BYTE_BOTH  = 2'h3;
  localparam logic [1:0] SPC_CPU    = 2'h0;
  localparam logic [1:0] SPC_USER   = 2'h1;
  localparam logic [1:0] SPC_SUPV   = 2'h2;
  localparam logic [1:0] SPC_SU     = 2'h3;
  localparam logic [3:0] ACK_FAST   = 4'he;
  localparam logic [3:0] ACK_EXT    = 4'hf;
  localparam logic [2:0] PRI_ANY    = 3'h0;
  localparam logic [1:0] PA_DISC    = 2'h0;
  localparam logic [1:0] PA_CS8     = 2'h2;
  localparam logic [1:0] PA_CS16    = 2'h3;
  localparam logic [2:0] FC_CPU     = 3'h7;
  localparam logic [2:0] FC_UDATA   = 3'h1;
  localparam logic [2:0] FC_UPROG   = 3'h2;
  localparam logic [2:0] FC_SDATA   = 3'h5;
  localparam logic [2:0] FC_SPROG   = 3'h6;
  localparam logic [3:0] IACK_TYPE  = 4'hf;
  localparam logic [1:0] SIZ_BYTE   = 2'h1;
  // reset values; channel 0 is the boot channel
  localparam logic [15:0] OPTION_RST      = 16'h0000;
  localparam logic [15:0] BOOT_OPTION_RST = 16'h7b70;
  localparam logic [15:0] BASE_RST        = 16'h0000;
  localparam logic [15:0] BOOT_BASE_RST   = 16'h0007;
  localparam logic [1:0]  PA_RST          = 2'h1;
  localparam logic [1:0]  BOOT_PA_RST     = 2'h3;
  localparam logic [6:0]  PORT_RST        = 7'h00;
  // channels whose pins carry discrete output bits
  localparam int DISC_FIRST = 4;
  localparam int DISC_LAST  = 10;
  // address compare mask over addr[23:11] per block size code
  function automatic logic [12:0] blk_mask(input logic [2:0] code);
    unique case (code)
      3'h0: blk_mask = 13'h1fff;
      3'h1: blk_mask = 13'h1ffc;
      3'h2: blk_mask = 13'h1ff8;
      3'h3: blk_mask = 13'h1fe0;
      3'h4: blk_mask = 13'h1fc0;
      3'h5: blk_mask = 13'h1f80;
      3'h6: blk_mask = 13'h1f00;
      3'h7: blk_mask = 13'h1e00;
    endcase
  endfunction
endpackage
